// ==== shared/tcsm_pkg.sv ====
// Constants for the telecom clock select multiplexer.
// Assumes a 32-bit APB register bus; each register occupies one aligned word.
package tcsm_pkg;

    // ==========================================================
    // Register indices and byte addresses (byte address = index * 4)
    localparam logic [11:0] IDX_OUT_A      = 12'h10E;
    localparam logic [11:0] IDX_OUT_B      = 12'h110;
    localparam logic [11:0] IDX_OUT_C      = 12'h112;
    localparam logic [11:0] IDX_OUT_D      = 12'h114;
    localparam logic [11:0] IDX_REF0       = 12'h116;
    localparam logic [11:0] IDX_REF1       = 12'h118;
    localparam logic [11:0] IDX_SYNTH_CTRL = 12'h120;

    localparam logic [11:0] ADDR_OUT_A      = {IDX_OUT_A[9:0], 2'b00};
    localparam logic [11:0] ADDR_OUT_B      = {IDX_OUT_B[9:0], 2'b00};
    localparam logic [11:0] ADDR_OUT_C      = {IDX_OUT_C[9:0], 2'b00};
    localparam logic [11:0] ADDR_OUT_D      = {IDX_OUT_D[9:0], 2'b00};
    localparam logic [11:0] ADDR_REF0       = {IDX_REF0[9:0], 2'b00};
    localparam logic [11:0] ADDR_REF1       = {IDX_REF1[9:0], 2'b00};
    localparam logic [11:0] ADDR_SYNTH_CTRL = {IDX_SYNTH_CTRL[9:0], 2'b00};

    // ==========================================================
    // Channel numbering: four backplane lines, then two references
    localparam int NUM_CHAN  = 6;
    localparam int CHAN_REF0 = 4;
    localparam int CHAN_REF1 = 5;

    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_OUT_SEL  = 16'h0000;
    localparam logic [15:0] RST_REF0_SEL = 16'h0011;
    localparam logic [15:0] RST_REF1_SEL = 16'h0000;
    localparam logic        RST_OOR      = 1'b0;

    // ==========================================================
    // Control field layout
    localparam int SYNTH_OOR_BIT = 7;
    localparam int SEL_WIDTH     = 16;

    // ==========================================================
    // Source select codes
    localparam logic [15:0] CODE_TRISTATE  = 16'h0000;
    localparam logic [15:0] CODE_LOW_LAST  = 16'h0010;
    localparam logic [15:0] CODE_CLK_A     = 16'h0011;
    localparam logic [15:0] CODE_CLK_D     = 16'h0014;
    localparam logic [15:0] CODE_FRAME     = 16'h0015;
    localparam logic [15:0] CODE_PLL_8M192 = 16'h0016;
    localparam logic [15:0] CODE_PLL_65M53 = 16'h0017;
    localparam logic [15:0] CODE_PLL_1M544 = 16'h0018;

    // Source vector positions, in code order starting at CODE_CLK_A
    localparam int NUM_SRC      = 8;
    localparam int SRC_FRAME    = 4;
    localparam int SRC_PLL_8M   = 5;
    localparam int SRC_PLL_65M  = 6;
    localparam int SRC_PLL_1M   = 7;

    // ==========================================================
    // Bus slave phase
    typedef enum logic [1:0] {
        TCSM_IDLE   = 2'b00,
        TCSM_ACCESS = 2'b01
    } tcsm_phase_e;

endpackage : tcsm_pkg

// ==== verif/tcsm_far_end.sv ====
// Far side: backplane sources, synthesizer outputs and the shared lines.
// Assumes the bench picks source levels; they move just after pclk edges.
`timescale 1ns/100ps
module tcsm_far_end (
    input  wire logic       pclk,
    input  wire logic [7:0] level_req,
    input  wire logic [3:0] line,
    input  wire logic [3:0] line_oe_n,
    output logic      [7:0] sources,
    output wire logic [3:0] bus_lvl
);
    // Order: clocks a..d, frame sync, 8.192, 65.536, 1.544 MHz
    initial sources = 8'h00;
    always @(posedge pclk) begin
        sources <= level_req;
    end
    // Released line floats; no pull on the backplane
    for (genvar i = 0; i < 4; i++) begin : g_bus
        assign bus_lvl[i] = line_oe_n[i] ? 1'bz : line[i];
    end
endmodule : tcsm_far_end

// ==== verif/tcsm_props.sv ====
// Concurrent checks on the clock select multiplexer ports.
// Assumes one pclk domain and an APB master that keeps the bus protocol.
`timescale 1ns/100ps
module tcsm_props #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  incoming_clock_a,
    input wire logic                  backplane_clock_line_a,
    input wire logic                  backplane_clock_line_a_oe_n,
    input wire logic                  synth_reference0,
    input wire logic                  synth_out_of_range_choice
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic       ref0_untouched;
    logic [2:0] settle;

    // =========================================================
    // Helper: reference 0 still at its reset code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref0_untouched <= 1'b1;
            settle         <= 3'd0;
        end else begin
            settle         <= (settle == 3'd4) ? settle : settle + 3'd1;
            ref0_untouched <= ref0_untouched
                              && !(psel && penable && pready && pwrite
                                   && paddr == tcsm_pkg::ADDR_REF0);
        end
    end

    // =========================================================
    // Sequences and properties
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_commit(logic [11:0] a);
        psel && penable && pready && pwrite && !pslverr && paddr == a;
    endsequence

    property p_ready_after_setup;
        s_setup |=> pready;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    property p_rdata_idle;
        !pready |-> prdata == 32'h0000_0000;
    endproperty
    property p_rdata_upper;
        pready |-> prdata[31:16] == 16'h0000;
    endproperty
    property p_unaligned;
        s_setup ##0 (paddr[1:0] != 2'b00) |=> pslverr && prdata == 32'h0000_0000;
    endproperty
    property p_oor_write;
        s_commit(tcsm_pkg::ADDR_SYNTH_CTRL) |-> ##2
            synth_out_of_range_choice == $past(pwdata[7], 2);
    endproperty
    property p_a_off;
        s_commit(tcsm_pkg::ADDR_OUT_A) ##0 (pwdata[15:0] == 16'h0000) |-> ##2
            backplane_clock_line_a_oe_n;
    endproperty
    property p_a_low;
        s_commit(tcsm_pkg::ADDR_OUT_A) ##0 (pwdata[15:0] inside {[16'h0001:16'h0010]}
            || pwdata[15:0] > 16'h0018) |-> ##2
            (!backplane_clock_line_a && !backplane_clock_line_a_oe_n);
    endproperty
    property p_ref0_off;
        s_commit(tcsm_pkg::ADDR_REF0) ##0 (pwdata[15:0] == 16'h0000) |-> ##2
            !synth_reference0 [*3];
    endproperty
    property p_ref0_default;
        ref0_untouched && settle == 3'd4 |-> synth_reference0 == $past(incoming_clock_a, 3);
    endproperty

    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");
    a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
    a_unaligned: assert property (p_unaligned) else $error("unaligned not refused");
    a_oor_write: assert property (p_oor_write) else $error("range bit wrong");
    a_a_off: assert property (p_a_off) else $error("line a not released");
    a_a_low: assert property (p_a_low) else $error("line a not low");
    a_ref0_off: assert property (p_ref0_off) else $error("reference 0 not low");
    a_ref0_default: assert property (p_ref0_default) else $error("ref 0 default");
endmodule : tcsm_props

bind tcsm_top tcsm_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .incoming_clock_a(incoming_clock_a), .backplane_clock_line_a(backplane_clock_line_a),
    .backplane_clock_line_a_oe_n(backplane_clock_line_a_oe_n),
    .synth_reference0(synth_reference0),
    .synth_out_of_range_choice(synth_out_of_range_choice)
);

// ==== verif/telecom_clock_select_mux_tb_top.sv ====
// Self-checking bench: APB register access and source routing.
// Assumes tcsm_top, its package and the far-side model are compiled first.
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module telecom_clock_select_mux_tb_top;
    localparam logic [11:0] ADDRS [6] = '{tcsm_pkg::ADDR_OUT_A, tcsm_pkg::ADDR_OUT_B,
        tcsm_pkg::ADDR_OUT_C, tcsm_pkg::ADDR_OUT_D, tcsm_pkg::ADDR_REF0, tcsm_pkg::ADDR_REF1};
    localparam logic [15:0] CODES [13] = '{16'h0000, 16'h0001, 16'h0010, 16'h0011, 16'h0012,
        16'h0013, 16'h0014, 16'h0015, 16'h0016, 16'h0017, 16'h0018, 16'h0019, 16'hFFFF};
    logic        pclk      = 1'b0;
    logic        presetn   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic [7:0]  level_req = 8'h00;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  sources;
    logic [3:0]  line_v;
    logic [3:0]  oe_v;
    wire  [3:0]  bus_lvl;
    logic        ref0;
    logic        ref1;
    logic        oor;
    logic [1:0]  got;
    int          n_fail     = 0;
    int          num_checks = 0;

    always #5 pclk = ~pclk;

    tcsm_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .incoming_clock_a(sources[0]), .incoming_clock_b(sources[1]),
        .incoming_clock_c(sources[2]), .incoming_clock_d(sources[3]),
        .timeslot_interchanger_frame_sync(sources[4]), .synth_out_8m192(sources[5]),
        .synth_out_65m536(sources[6]), .synth_out_1m544(sources[7]),
        .backplane_clock_line_a(line_v[0]), .backplane_clock_line_a_oe_n(oe_v[0]),
        .backplane_clock_line_b(line_v[1]), .backplane_clock_line_b_oe_n(oe_v[1]),
        .backplane_clock_line_c(line_v[2]), .backplane_clock_line_c_oe_n(oe_v[2]),
        .backplane_clock_line_d(line_v[3]), .backplane_clock_line_d_oe_n(oe_v[3]),
        .synth_reference0(ref0), .synth_reference1(ref1), .synth_out_of_range_choice(oor)
    );
    tcsm_far_end u_far (
        .pclk(pclk), .level_req(level_req), .line(line_v), .line_oe_n(oe_v),
        .sources(sources), .bus_lvl(bus_lvl)
    );

    // =========================================================
    // Bus tasks
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1) begin
            n_fail++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
        `CHK(err, e)
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic e);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        `CHK({err, rd}, {e, x})
    endtask : rd_chk

    // {oe_n, wire level}; released lines float
    function automatic logic [1:0] exp_out(input logic [15:0] c, input logic [7:0] p,
                                           input int ch);
        if (c == tcsm_pkg::CODE_TRISTATE && ch < tcsm_pkg::CHAN_REF0) return 2'b1z;
        if (c >= tcsm_pkg::CODE_CLK_A && c <= tcsm_pkg::CODE_PLL_1M544) begin
            return {1'b0, p[c - tcsm_pkg::CODE_CLK_A]};
        end
        return 2'b00;
    endfunction : exp_out

    // =========================================================
    // Test sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd_chk(ADDRS[i], {16'h0000, (i == 4) ? tcsm_pkg::RST_REF0_SEL
                                                 : tcsm_pkg::RST_OUT_SEL}, 1'b0);
        end
        rd_chk(tcsm_pkg::ADDR_SYNTH_CTRL, 32'h0000_0000, 1'b0);
        `CHK(oor, tcsm_pkg::RST_OOR)
        for (int j = 0; j < 2; j++) begin
            level_req <= j ? 8'h00 : 8'h01;
            repeat (6) @(posedge pclk);
            `CHK(ref0, (j == 0))
        end
        $display("test reset_values done");

        for (int ch = 0; ch < 6; ch++) begin
            for (int k = 0; k < 13; k++) begin
                wr(ADDRS[ch], {16'hA5A5, CODES[k]}, 1'b0);
                for (int j = 0; j < 2; j++) begin
                    level_req <= j ? 8'h5A : 8'hA5;
                    repeat (6) @(posedge pclk);
                    got = (ch < 4) ? {oe_v[ch], bus_lvl[ch]} : {1'b0, (ch == 4) ? ref0 : ref1};
                    `CHK(got, exp_out(CODES[k], level_req, ch))
                end
            end
        end
        $display("test routing done");

        for (int i = 0; i < 6; i++) begin
            wr(ADDRS[i], 32'hFFFF_0000 | (32'h1234 + i), 1'b0);
            rd_chk(ADDRS[i], 32'h1234 + i, 1'b0);
        end
        wr(tcsm_pkg::ADDR_SYNTH_CTRL, 32'h0000_FFFF, 1'b0);
        rd_chk(tcsm_pkg::ADDR_SYNTH_CTRL, 32'h0000_0080, 1'b0);
        `CHK(oor, 1'b1)
        wr(tcsm_pkg::ADDR_SYNTH_CTRL, 32'h0000_0000, 1'b0);
        repeat (2) @(posedge pclk);
        `CHK(oor, 1'b0)
        $display("test register_access done");

        rd_chk(12'h468, 32'h0000_0000, 1'b1);
        wr(12'h468, 32'h0000_0015, 1'b1);
        wr(12'h439, 32'h0000_0000, 1'b1);
        rd_chk(tcsm_pkg::ADDR_OUT_A, 32'h0000_1234, 1'b0);
        $display("test refused_access done");
        finish_test();
    end
endmodule : telecom_clock_select_mux_tb_top

// ==== verilog/tcsm_sel_mux.sv ====
// One output channel: decodes a 16-bit source code and registers the line.
// Assumes all sources are already synchronised to pclk.
`timescale 1ns/100ps
module tcsm_sel_mux #(
    parameter bit TRISTATE_OK = 1'b1
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic [15:0]                  source_code,
    input  wire logic [tcsm_pkg::NUM_SRC-1:0] sources,
    output logic                              line_out,
    output logic                              line_oe_n
);

    // ==========================================================
    // State
    typedef struct packed {
        logic line;
        logic oe_n;
    } tcsm_mux_s;

    tcsm_mux_s state_reg;
    tcsm_mux_s state_next;
    logic [15:0] src_offset;

    always_comb begin
        state_next = state_reg;
        src_offset = source_code - tcsm_pkg::CODE_CLK_A;
        state_next.line = 1'b0;
        state_next.oe_n = 1'b0;
        if (source_code == tcsm_pkg::CODE_TRISTATE) begin
            // Lines that may float release, references drive low
            state_next.oe_n = TRISTATE_OK;
        end else if (source_code <= tcsm_pkg::CODE_LOW_LAST) begin
            state_next.line = 1'b0;
        end else if (source_code <= tcsm_pkg::CODE_CLK_D) begin
            state_next.line = sources[src_offset[2:0]];
        end else if (source_code == tcsm_pkg::CODE_FRAME) begin
            state_next.line = sources[tcsm_pkg::SRC_FRAME];
        end else if (source_code == tcsm_pkg::CODE_PLL_8M192) begin
            state_next.line = sources[tcsm_pkg::SRC_PLL_8M];
        end else if (source_code == tcsm_pkg::CODE_PLL_65M53) begin
            state_next.line = sources[tcsm_pkg::SRC_PLL_65M];
        end else if (source_code == tcsm_pkg::CODE_PLL_1M544) begin
            state_next.line = sources[tcsm_pkg::SRC_PLL_1M];
        end else begin
            state_next.line = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.line <= 1'b0;
            state_reg.oe_n <= TRISTATE_OK;
        end else begin
            state_reg <= state_next;
        end
    end

    assign line_out  = state_reg.line;
    assign line_oe_n = state_reg.oe_n;

endmodule : tcsm_sel_mux

// ==== verilog/tcsm_sync2.sv ====
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes the inputs are unrelated to pclk; bits are synchronised independently.
`timescale 1ns/100ps
module tcsm_sync2 #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    generate
        if (WIDTH < 1) begin : g_chk
            $error("tcsm_sync2: WIDTH must be at least 1");
        end
    endgenerate

    // ==========================================================
    // State
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } tcsm_sync_s;

    tcsm_sync_s state_reg;
    tcsm_sync_s state_next;

    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = async_in;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stage2;

endmodule : tcsm_sync2

// ==== verilog/tcsm_top.sv ====
// Telecom clock select multiplexer with its APB register file.
// Assumes incoming clocks and synthesizer outputs are asynchronous to pclk;
// each is synchronised and re-registered, so routed clocks carry pclk jitter.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps

module tcsm_top #(
    parameter int ADDR_WIDTH = 12
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  incoming_clock_a,
    input  wire logic                  incoming_clock_b,
    input  wire logic                  incoming_clock_c,
    input  wire logic                  incoming_clock_d,
    input  wire logic                  timeslot_interchanger_frame_sync,
    input  wire logic                  synth_out_8m192,
    input  wire logic                  synth_out_65m536,
    input  wire logic                  synth_out_1m544,
    output logic                       backplane_clock_line_a,
    output logic                       backplane_clock_line_a_oe_n,
    output logic                       backplane_clock_line_b,
    output logic                       backplane_clock_line_b_oe_n,
    output logic                       backplane_clock_line_c,
    output logic                       backplane_clock_line_c_oe_n,
    output logic                       backplane_clock_line_d,
    output logic                       backplane_clock_line_d_oe_n,
    output logic                       synth_reference0,
    output logic                       synth_reference1,
    output logic                       synth_out_of_range_choice
);

    localparam int NCH = tcsm_pkg::NUM_CHAN;
    localparam int NSR = tcsm_pkg::NUM_SRC;

    generate
        if (ADDR_WIDTH < 12 || ADDR_WIDTH > 32) begin : g_chk
            $error("tcsm_top: ADDR_WIDTH must lie between 12 and 32");
        end
        if (tcsm_pkg::NUM_SRC != 8 || tcsm_pkg::CHAN_REF1 >= NCH) begin : g_map_chk
            $error("tcsm_top: package source or channel counts do not fit");
        end
    endgenerate

    // ==========================================================
    // State
    typedef struct packed {
        tcsm_pkg::tcsm_phase_e   phase;
        logic [NCH-1:0][15:0]    sel;
        logic                    oor;
        logic                    ready;
        logic                    err;
        logic [31:0]             rdata;
    } tcsm_regs_s;

    tcsm_regs_s state_reg;
    tcsm_regs_s state_next;

    // ==========================================================
    // Address decode
    logic [11:0]    word_addr;
    logic           addr_high_zero;
    logic           addr_aligned;
    logic           hit_sel;
    logic           hit_ctrl;
    logic [2:0]     hit_chan;
    logic           mapped;
    logic [31:0]    read_value;

    assign addr_aligned = (paddr[1:0] == 2'b00);
    assign word_addr    = paddr[11:0];

    generate
        if (ADDR_WIDTH > 12) begin : g_hi
            assign addr_high_zero = (paddr[ADDR_WIDTH-1:12] == '0);
        end else begin : g_nohi
            assign addr_high_zero = 1'b1;
        end
    endgenerate

    always_comb begin
        hit_sel  = 1'b0;
        hit_ctrl = 1'b0;
        hit_chan = 3'h0;
        unique case (word_addr)
            tcsm_pkg::ADDR_OUT_A: begin
                hit_sel  = 1'b1;
                hit_chan = 3'h0;
            end
            tcsm_pkg::ADDR_OUT_B: begin
                hit_sel  = 1'b1;
                hit_chan = 3'h1;
            end
            tcsm_pkg::ADDR_OUT_C: begin
                hit_sel  = 1'b1;
                hit_chan = 3'h2;
            end
            tcsm_pkg::ADDR_OUT_D: begin
                hit_sel  = 1'b1;
                hit_chan = 3'h3;
            end
            tcsm_pkg::ADDR_REF0: begin
                hit_sel  = 1'b1;
                hit_chan = 3'(tcsm_pkg::CHAN_REF0);
            end
            tcsm_pkg::ADDR_REF1: begin
                hit_sel  = 1'b1;
                hit_chan = 3'(tcsm_pkg::CHAN_REF1);
            end
            tcsm_pkg::ADDR_SYNTH_CTRL: begin
                hit_ctrl = 1'b1;
            end
            default: begin
                hit_sel  = 1'b0;
                hit_ctrl = 1'b0;
            end
        endcase
        if (!addr_aligned || !addr_high_zero) begin
            hit_sel  = 1'b0;
            hit_ctrl = 1'b0;
        end
    end

    assign mapped = hit_sel | hit_ctrl;

    // ==========================================================
    // Bus phase qualifiers; a write lands only on a completed access
    logic setup_seen;
    logic commit_write;

    assign setup_seen   = psel && !penable;
    assign commit_write = psel && penable && state_reg.ready && pwrite;

    // Read mux; reserved and upper bits read zero
    always_comb begin
        read_value = 32'h0000_0000;
        if (hit_sel) begin
            read_value[15:0] = state_reg.sel[hit_chan];
        end else if (hit_ctrl) begin
            read_value[tcsm_pkg::SYNTH_OOR_BIT] = state_reg.oor;
        end
    end

    // ==========================================================
    // APB slave: pready one cycle after setup, write at completion edge
    always_comb begin
        state_next       = state_reg;
        state_next.ready = 1'b0;
        unique case (state_reg.phase)
            tcsm_pkg::TCSM_IDLE: begin
                if (setup_seen) begin
                    state_next.phase = tcsm_pkg::TCSM_ACCESS;
                    state_next.ready = 1'b1;
                    state_next.err   = !mapped;
                    state_next.rdata = (!pwrite && mapped) ? read_value : 32'h0000_0000;
                end
            end
            tcsm_pkg::TCSM_ACCESS: begin
                state_next.phase = tcsm_pkg::TCSM_IDLE;
                state_next.err   = 1'b0;
                state_next.rdata = 32'h0000_0000;
                if (commit_write) begin
                    if (hit_sel) begin
                        state_next.sel[hit_chan] = pwdata[15:0];
                    end else if (hit_ctrl) begin
                        state_next.oor = pwdata[tcsm_pkg::SYNTH_OOR_BIT];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.phase   <= tcsm_pkg::TCSM_IDLE;
            state_reg.sel[0]  <= tcsm_pkg::RST_OUT_SEL;
            state_reg.sel[1]  <= tcsm_pkg::RST_OUT_SEL;
            state_reg.sel[2]  <= tcsm_pkg::RST_OUT_SEL;
            state_reg.sel[3]  <= tcsm_pkg::RST_OUT_SEL;
            state_reg.sel[tcsm_pkg::CHAN_REF0] <= tcsm_pkg::RST_REF0_SEL;
            state_reg.sel[tcsm_pkg::CHAN_REF1] <= tcsm_pkg::RST_REF1_SEL;
            state_reg.oor     <= tcsm_pkg::RST_OOR;
            state_reg.ready   <= 1'b0;
            state_reg.err     <= 1'b0;
            state_reg.rdata   <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata                    = state_reg.rdata;
    assign pready                    = state_reg.ready;
    assign pslverr                   = state_reg.err;
    assign synth_out_of_range_choice = state_reg.oor;

    // ==========================================================
    // Source synchronisation, in code order from first clock code
    logic [NSR-1:0] src_async;
    logic [NSR-1:0] src_sync;

    assign src_async[0] = incoming_clock_a;
    assign src_async[1] = incoming_clock_b;
    assign src_async[2] = incoming_clock_c;
    assign src_async[3] = incoming_clock_d;
    assign src_async[4] = timeslot_interchanger_frame_sync;
    assign src_async[5] = synth_out_8m192;
    assign src_async[6] = synth_out_65m536;
    assign src_async[7] = synth_out_1m544;

    tcsm_sync2 #(
        .WIDTH (NSR)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (src_async),
        .sync_out (src_sync)
    );

    // ==========================================================
    // Output channels: four lines may float, references never do
    logic [NCH-1:0] chan_line;
    logic [NCH-1:0] chan_oe_n;

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            tcsm_sel_mux #(
                .TRISTATE_OK ((ch < tcsm_pkg::CHAN_REF0) ? 1'b1 : 1'b0)
            ) u_mux (
                .pclk        (pclk),
                .presetn     (presetn),
                .source_code (state_reg.sel[ch]),
                .sources     (src_sync),
                .line_out    (chan_line[ch]),
                .line_oe_n   (chan_oe_n[ch])
            );
        end
    endgenerate

    assign backplane_clock_line_a      = chan_line[0];
    assign backplane_clock_line_a_oe_n = chan_oe_n[0];
    assign backplane_clock_line_b      = chan_line[1];
    assign backplane_clock_line_b_oe_n = chan_oe_n[1];
    assign backplane_clock_line_c      = chan_line[2];
    assign backplane_clock_line_c_oe_n = chan_oe_n[2];
    assign backplane_clock_line_d      = chan_line[3];
    assign backplane_clock_line_d_oe_n = chan_oe_n[3];
    assign synth_reference0            = chan_line[tcsm_pkg::CHAN_REF0];
    assign synth_reference1            = chan_line[tcsm_pkg::CHAN_REF1];

endmodule : tcsm_top
